// ---- logic/swc_consts.vh ----
// Constants for the capture window block: register offsets, widths, fixed status bits.
// Included by the capture window module only.
`ifndef SWC_CONSTS_VH
`define SWC_CONSTS_VH
`define SWC_ADDR_W 8
`define SWC_OFS_STAT_LO 8'h2C
`define SWC_OFS_STAT_MID 8'h2D
`define SWC_OFS_STAT_HI 8'h2E
`define SWC_NUM_TAPS 24
`define SWC_NUM_SEL 16
`define SWC_SEL_W 4
`define SWC_TAP_FIRST 0
`define SWC_TAP_LAST 23
`define SWC_BYTE_W 8
`define SWC_CNT_W 12
`define SWC_CNT_RST 12'h000
`define SWC_LO_BASE 0
`define SWC_MID_BASE 8
`define SWC_HI_BASE 16
`define SWC_FMT_8B10B 1'b0
`define SWC_FMT_64B66B 1'b1
`endif

// ---- logic/swc_window_capture.v ----
// Timing reference window capture: position detector, phase select, counter reset.
// Assumes the delay line outside delivers tap samples synchronous to ref_clk.
`timescale 1ns/1ps
`include "swc_consts.vh"
module swc_window_capture #(
  parameter NUM_TAPS = `SWC_NUM_TAPS,
  parameter CNT_W = `SWC_CNT_W
) (
  input wire ref_clk, // Device reference clock
  input wire rst, // Synchronous reset, active high
  input wire [NUM_TAPS-1:0] tap_sample, // Reference sampled at each delayed instant
  input wire [`SWC_SEL_W-1:0] capture_phase_select, // Chosen instant index
  input wire fine_delay_step, // 1 fine delay steps, 0 coarse
  input wire link_format_setting, // 0 8b/10b, 1 64b/66b
  input wire [CNT_W-1:0] period_len, // Multiframe or extended multiblock length, clocks
  input wire [`SWC_ADDR_W-1:0] reg_addr, // Register read address
  output reg [`SWC_BYTE_W-1:0] reg_rdata, // Register read data
  output reg delay_step_fine, // Drives delay line step size
  output reg sysref_captured, // Pulse on each captured reference edge
  output reg [CNT_W-1:0] lmfc_count_q, // Local multiframe counter
  output reg [CNT_W-1:0] lemc_count_q // Local extended multiblock counter
);
  // Per-instant status and its registered copy
  wire [NUM_TAPS-1:0] status_d;
  reg [NUM_TAPS-1:0] status_q;

  // Capture path
  wire cap_d;
  reg cap_q;
  wire pulse_d;
  wire step_d;

  // Counter control and next values
  wire [CNT_W-1:0] cnt_one;
  wire [CNT_W-1:0] cnt_last;
  wire lmfc_align;
  wire lemc_align;
  wire lmfc_wrap;
  wire lemc_wrap;
  reg [CNT_W-1:0] lmfc_count_d;
  reg [CNT_W-1:0] lemc_count_d;

  // Register read path
  wire hit_lo;
  wire hit_mid;
  wire hit_hi;
  wire [`SWC_BYTE_W-1:0] stat_lo;
  wire [`SWC_BYTE_W-1:0] stat_mid;
  wire [`SWC_BYTE_W-1:0] stat_hi;
  reg [`SWC_BYTE_W-1:0] rdata_d;

  genvar i;

  // A level change against either neighbour marks an instant as marginal
  generate
    for (i = 0; i < NUM_TAPS; i = i + 1) begin : g_pos
      if (i == `SWC_TAP_FIRST || i == NUM_TAPS - 1) begin : g_edge
        // One neighbour is missing, so the margin cannot be judged
        assign status_d[i] = 1'b1;
      end else begin : g_mid
        assign status_d[i] = (tap_sample[i] ^ tap_sample[i-1]) |
                             (tap_sample[i] ^ tap_sample[i+1]);
      end

      // Refreshed every cycle, so a read shows the window as it stands now
      always @(posedge ref_clk) begin
        if (rst) begin
          status_q[i] <= 1'b1;
        end else begin
          status_q[i] <= status_d[i];
        end
      end
    end
  endgenerate

  // Four select bits only reach the first sixteen instants; upper bits are report only
  assign cap_d = tap_sample[capture_phase_select];

  // Rising edge only: a lone pulse and a periodic reference are treated alike
  assign pulse_d = cap_d & ~cap_q;

  assign step_d = fine_delay_step;

  // Cleared by reset, so a reference idling low gives no false edge afterwards
  always @(posedge ref_clk) begin
    if (rst) begin
      cap_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      sysref_captured <= 1'b0;
    end else begin
      sysref_captured <= pulse_d;
    end
  end

  // Coarse steps after reset; the delay line follows the control one cycle later
  always @(posedge ref_clk) begin
    if (rst) begin
      delay_step_fine <= 1'b0;
    end else begin
      delay_step_fine <= step_d;
    end
  end

  // The counter of the active format restarts on every captured edge, so alignment repeats across devices
  // A period_len of one keeps the counters parked at zero; zero gives a full 4096-clock period
  assign cnt_one = {{(CNT_W-1){1'b0}}, 1'b1};
  assign cnt_last = period_len - cnt_one;
  assign lmfc_align = sysref_captured & (link_format_setting == `SWC_FMT_8B10B);
  assign lemc_align = sysref_captured & (link_format_setting == `SWC_FMT_64B66B);
  assign lmfc_wrap = (lmfc_count_q >= cnt_last);
  assign lemc_wrap = (lemc_count_q >= cnt_last);

  always @* begin
    if (lmfc_align) begin
      lmfc_count_d = {CNT_W{1'b0}};
    end else if (lmfc_wrap) begin
      lmfc_count_d = {CNT_W{1'b0}};
    end else begin
      lmfc_count_d = lmfc_count_q + cnt_one;
    end
  end

  always @* begin
    if (lemc_align) begin
      lemc_count_d = {CNT_W{1'b0}};
    end else if (lemc_wrap) begin
      lemc_count_d = {CNT_W{1'b0}};
    end else begin
      lemc_count_d = lemc_count_q + cnt_one;
    end
  end

  // Only the counter of the active format is realigned; the other runs free
  always @(posedge ref_clk) begin
    if (rst) begin
      lmfc_count_q <= {CNT_W{1'b0}};
    end else begin
      lmfc_count_q <= lmfc_count_d;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      lemc_count_q <= {CNT_W{1'b0}};
    end else begin
      lemc_count_q <= lemc_count_d;
    end
  end

  // Address decode, done once for the read mux
  assign hit_lo = (reg_addr == `SWC_OFS_STAT_LO);
  assign hit_mid = (reg_addr == `SWC_OFS_STAT_MID);
  assign hit_hi = (reg_addr == `SWC_OFS_STAT_HI);

  // Status bytes as the host sees them at the three read offsets
  assign stat_lo = status_q[`SWC_LO_BASE +: `SWC_BYTE_W];
  assign stat_mid = status_q[`SWC_MID_BASE +: `SWC_BYTE_W];
  assign stat_hi = status_q[`SWC_HI_BASE +: `SWC_BYTE_W];

  always @* begin
    case (1'b1)
      hit_lo: begin
        rdata_d = stat_lo;
      end
      hit_mid: begin
        rdata_d = stat_mid;
      end
      hit_hi: begin
        rdata_d = stat_hi;
      end
      // Unmapped offsets read as zero
      default: begin
        rdata_d = {`SWC_BYTE_W{1'b0}};
      end
    endcase
  end

  // Registered so read data stands one full cycle after the address is taken
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= {`SWC_BYTE_W{1'b0}};
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule // swc_window_capture

// ---- tb/swc_chk_checker.sv ----
// Port assertions bound to swc_window_capture; one clock, synchronous reset.
`timescale 1ns/1ps
module swc_chk (input wire ref_clk, rst, sysref_captured, link_format_setting,
  input wire [23:0] tap_sample, input wire [3:0] capture_phase_select,
  input wire [7:0] reg_addr, reg_rdata, input wire [11:0] lmfc_count_q, lemc_count_q);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_low_end: assert property (reg_addr == 8'h2C |=> reg_rdata[0]) else $error("bit 0");
  a_top_end: assert property (reg_addr == 8'h2E |=> reg_rdata[7]) else $error("bit 23");
  a_hole_zero: assert property (reg_addr > 8'h2E |=> !reg_rdata) else $error("hole");
  a_quiet_taps: assert property ($stable(tap_sample)[*3] ##0 !tap_sample && reg_addr == 8'h2C
    |=> reg_rdata == 8'h01) else $error("quiet");
  a_tap_rise: assert property ($rose(tap_sample[capture_phase_select])
    |=> sysref_captured) else $error("no pulse");
  a_pulse_once: assert property (sysref_captured |=> !sysref_captured) else $error("wide");
  a_lmfc_zero: assert property (sysref_captured && !link_format_setting |=> !lmfc_count_q)
    else $error("lmfc");
  a_lemc_zero: assert property (sysref_captured && link_format_setting |=> !lemc_count_q)
    else $error("lemc");
  cover property (sysref_captured && link_format_setting);
  cover property (sysref_captured && !link_format_setting);
  cover property (reg_addr == 8'h2E ##1 reg_rdata[7]);
endmodule // swc_chk

// ---- tb/swc_ref_gen.sv ----
// Source model: the reference level as each delayed tap sees it; taps from pos upward see it.
`timescale 1ns/1ps
module swc_ref_gen (input wire lvl, input wire [4:0] pos, output wire [23:0] tap_sample);
  assign tap_sample = lvl ? 24'hFFFFFF << pos : 24'h000000;
endmodule // swc_ref_gen

// ---- tb/test_swc_window_capture.sv ----
// Bench: random edge positions over every selection and both formats, status byte reads.
`timescale 1ns/1ps
module test_swc_window_capture;
  reg ref_clk = 0, rst = 1, lvl = 0, fmt = 0, fine = 0, fmt_d = 0, cnt_due = 0;
  reg [4:0] pos = 5'h01, sel = 5'h00;
  reg [7:0] addr = 8'h00, q[$];
  reg qf[$], qc[$];
  reg [23:0] e = 24'h000000;
  wire [23:0] taps;
  wire [7:0] rdata;
  wire step, cap;
  wire [11:0] lmfc, lemc;
  integer fail_count = 0, checks = 0, i, a, b;
  always #5 ref_clk = ~ref_clk;
  swc_ref_gen u_swc_ref_gen (.lvl(lvl), .pos(pos), .tap_sample(taps));
  // The reference rises every 16 clocks, exactly two counter periods of 8
  swc_window_capture u_swc_window_capture (.ref_clk(ref_clk), .rst(rst), .tap_sample(taps),
    .capture_phase_select(sel[3:0]), .fine_delay_step(fine), .link_format_setting(fmt),
    .period_len(12'h008), .reg_addr(addr), .reg_rdata(rdata), .delay_step_fine(step),
    .sysref_captured(cap), .lmfc_count_q(lmfc), .lemc_count_q(lemc));
  // A capture that was expected and never came counts as a mismatch
  task wrap_up;
    fail_count = fail_count + qc.size();
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Registered outputs are looked at on the falling edge, where they have settled
  always @(negedge ref_clk) begin
    if (cnt_due) begin
      checks = checks + 1;
      if ((fmt_d ? lemc : lmfc) !== 12'h000) begin
        $display("wrong value active_counter exp %h got %h", 12'h000, fmt_d ? lemc : lmfc);
        fail_count = fail_count + 1;
      end
    end
    cnt_due = 0;
    if (cap !== 1'b0) begin
      checks = checks + 1;
      if (qc.size() == 0) begin
        $display("wrong value sysref_captured exp %h got %h", 1'b0, cap);
        fail_count = fail_count + 1;
      end else begin
        fmt_d = qc.pop_front();
        cnt_due = 1;
      end
    end
    if (q.size()) begin
      checks = checks + 2;
      if (q[0] !== rdata) begin
        $display("wrong value reg_rdata exp %h got %h", q[0], rdata);
        fail_count = fail_count + 1;
      end
      if (qf[0] !== step) begin
        $display("wrong value delay_step_fine exp %h got %h", qf[0], step);
        fail_count = fail_count + 1;
      end
      void'(q.pop_front());
      void'(qf.pop_front());
    end
  end
  initial begin
    a = $urandom(84);
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    for (i = 0; i < 32; i = i + 1) begin
      a = 1 + $urandom % 22;
      // Every index once per format, lowest first, reloaded on each pass
      @(posedge ref_clk) {lvl, fmt, sel} <= {1'b0, i[4], 1'b0, i[3:0]};
      fine <= ($urandom % 4) != 0;
      repeat (4) @(posedge ref_clk);
      {lvl, pos} <= {1'b1, a[4:0]};
      if (sel >= a) qc.push_back(fmt);
      repeat (3) @(posedge ref_clk);
      for (b = 47; b > 43; b = b - 1) begin
        @(posedge ref_clk) addr <= b[7:0];
        e = (24'h800001 | 24'h000003 << (a - 1)) >> 8 * (b - 44);
        @(posedge ref_clk) q.push_back(b > 46 ? 8'h00 : e[7:0]);
        qf.push_back(fine);
      end
    end
    wrap_up;
  end
  // The sweep needs about 520 cycles; this allows nearly four times that
  initial begin
    #20000 fail_count = fail_count + 1;
    wrap_up;
  end
endmodule // test_swc_window_capture
bind swc_window_capture swc_chk u_swc_chk (.*);
